// *** hdl/pcg_regs.sv ***
// Control word file and clock dividers of the programmable clock generator
//
// Summary of operation
// - Load divide-by-one disables horizontal and load outputs
// - Load clock 50%, odd moduli high one shorter
// - Word 14 delays system clock by pixels
// - Word 15 delays gated clock by system ticks
// - Horizontal modulus is eleven-bit value plus one
// - Horizontal output high one load period per cycle
// - Dual-modulus value is sixteen-bit words zero-three
// - Dual-modulus output high thirty-two oscillator periods
// - Modulus equals 32(B-Ainv) plus 31(1+Ainv)
// - Enable rising edge stores data at address
// - Mode bit selects dual-modulus or horizontal meaning
// - Horizontal value starts word one bit one
// - Reset selects crystal for system clock
// - Reset leaves oscillator enabled
// - Reset clears oscillator test mode
// - Oscillator reset bit self-clears after restart
// - Mode bit low horizontal, high dual-modulus
// - Tristate bit high floats feedback pin
`timescale 1ns/1ns
module pcg_regs
    import pcg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] ctl_addr,
    input wire logic [3:0] ctl_data,
    input wire logic ctl_enable,
    input wire logic vco_clk_in,
    input wire logic pixel_clk_in,
    input wire logic xtal_clk_in,
    input wire logic ref_div_in,
    input wire logic feedback_pin_i,
    output logic feedback_pin_o,
    output logic feedback_pin_oe,
    output logic comparator_fbk,
    output pcg_clocks_t clk_out,
    output pcg_analog_t analog_ctl,
    output logic ref_out_disable
);
    // Sixteen write-only control words; no readback port exists
    logic [3:0] ctl_r [16];
    logic enable_r;
    logic vco_r;
    logic pix_r;
    logic [7:0] restart_r;
    logic [15:0] sys_sh_r;
    logic [15:0] gated_sh_r;
    logic sys_clk_r;
    logic gated_clk_r;
    logic load_r;
    logic fb_r;

    // Write strobe is taken on its rising edge; the host keeps lines still
    wire write_fire = ctl_enable && !enable_r;
    wire vco_tick = vco_clk_in && !vco_r;
    wire pix_tick = pixel_clk_in && !pix_r;

    // Named views of the control words
    wire [3:0] w_fb_cfg = ctl_r[PCG_ADR_FB_CFG];
    wire [3:0] w_osc = ctl_r[PCG_ADR_OSC_CTL];
    wire [3:0] w_out = ctl_r[PCG_ADR_OUT_PUMP];
    wire [3:0] w_aux = ctl_r[PCG_ADR_AUX_DIS];
    wire [3:0] w_pix = ctl_r[PCG_ADR_PIX_POL];
    wire [3:0] sys_div = ctl_r[PCG_ADR_SYS_DIV];
    wire [3:0] load_div = ctl_r[PCG_ADR_LOAD_DIV];
    wire [3:0] system_phase_delay = ctl_r[PCG_ADR_SYS_PHASE];
    wire [3:0] gated_phase_delay = ctl_r[PCG_ADR_GATED_PHASE];

    wire divider_mode_select = w_fb_cfg[PCG_BIT_MODE_SEL];
    wire feedback_output_tristate = w_fb_cfg[PCG_BIT_FB_TRI];
    wire sys_src_divider = w_fb_cfg[PCG_BIT_SYS_SRC];
    wire pixel_polarity_invert = w_pix[PCG_BIT_PIX_INV];
    wire ttl_pixel_out_disable = w_out[PCG_BIT_TTL_PIX_DIS];
    wire ttl_gated_out_disable = w_out[PCG_BIT_TTL_GATED_DIS];
    wire load_out_disable = w_aux[PCG_BIT_LOAD_DIS];

    // Words zero to three read two ways depending on the mode bit
    wire [15:0] dual_modulus_value =
        {ctl_r[PCG_ADR_FB_NIB3], ctl_r[PCG_ADR_FB_NIB2],
         ctl_r[PCG_ADR_FB_NIB1], ctl_r[PCG_ADR_FB_NIB0]};
    wire [10:0] horizontal_divide_value = dual_modulus_value[15:5];

    // Prescaler form of the modulus; reduces to the plain binary value
    function automatic logic [15:0] nmod_fn(input logic [15:0] v);
        logic [16:0] b;
        logic [16:0] a_inv;
        logic [16:0] sum;
        b = {6'h00, v[15:5]};
        a_inv = {12'h000, ~v[4:0]};
        sum = 17'((b - a_inv) << 5) + 17'((17'h0_0001 + a_inv) * 17'h0_001f);
        return sum[15:0];
    endfunction : nmod_fn

    // Control word storage; oscillator reset bit self-clears after restart
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_word
            wire hit = write_fire && (ctl_addr == 4'(gi));
            if (gi == 12)
            begin : g_osc
                wire done = (restart_r == 8'h01);
                always_ff @(posedge clk_sys)
                begin
                    if (!rst_b)
                        ctl_r[gi] <= PCG_CTL_RESET;
                    else if (hit)
                        ctl_r[gi] <= ctl_data;
                    else if (done)
                        ctl_r[gi][PCG_BIT_OSC_RST] <= 1'b0;
                end
            end
            else
            begin : g_plain
                always_ff @(posedge clk_sys)
                begin
                    if (!rst_b)
                        ctl_r[gi] <= PCG_CTL_RESET;
                    else if (hit)
                        ctl_r[gi] <= ctl_data;
                end
            end
        end
    endgenerate

    // Restart sequence timer; a new write of the bit restarts it
    wire restart_start = write_fire && (ctl_addr == PCG_ADR_OSC_CTL)
        && ctl_data[PCG_BIT_OSC_RST];
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            restart_r <= 8'h00;
        else if (restart_start)
            restart_r <= PCG_RESTART_CNT;
        else if (restart_r != 8'h00)
            restart_r <= restart_r - 8'h01;
    end

    // Edge detectors for strobe and the incoming clock levels
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            enable_r <= 1'b0;
            vco_r <= 1'b0;
            pix_r <= 1'b0;
        end
        else
        begin
            enable_r <= ctl_enable;
            vco_r <= vco_clk_in;
            pix_r <= pixel_clk_in;
        end
    end

    // System clock divider on pixel ticks; modulus is word plus one
    logic s_out;
    logic s_term;
    wire [4:0] s_mod = {1'b0, sys_div} + 5'h01;
    pcg_div #(.W(5)) u_sys_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(1'b1),
        .tick(pix_tick),
        .modulus(s_mod),
        .high_len({1'b0, s_mod[4:1]}),
        .out_lvl(s_out),
        .term(s_term)
    );
    // Divide by one hands pixel rate straight to the load divider
    wire s_tick = (sys_div == 4'h0) ? pix_tick : s_term;

    // Load clock divider; divide by one stops it and the horizontal count
    logic l_out;
    logic l_term;
    wire [4:0] l_mod = {1'b0, load_div} + 5'h01;
    wire l_run = (load_div != 4'h0);
    pcg_div #(.W(5)) u_load_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(l_run),
        .tick(s_tick),
        .modulus(l_mod),
        .high_len({1'b0, l_mod[4:1]}),
        .out_lvl(l_out),
        .term(l_term)
    );

    // Horizontal divider counts load clock rising edges
    logic h_out;
    wire h_run = l_run && !divider_mode_select;
    pcg_div #(.W(12)) u_horiz_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(h_run),
        .tick(l_term),
        .modulus({1'b0, horizontal_divide_value} + 12'h001),
        .high_len(PCG_H_HIGH_LEN),
        .out_lvl(h_out),
        .term()
    );

    // Dual-modulus divider counts oscillator periods
    logic n_out;
    wire [15:0] n_mod = nmod_fn(dual_modulus_value);
    wire n_run = divider_mode_select && (n_mod != 16'h0000);
    pcg_div #(.W(16)) u_dual_div (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(n_run),
        .tick(vco_tick),
        .modulus(n_mod),
        .high_len(PCG_N_HIGH_LEN),
        .out_lvl(n_out),
        .term()
    );

    // Phase delay lines; tap zero is the undelayed source
    wire [15:0] sys_taps = {sys_sh_r[14:0], s_out};
    wire [15:0] gated_taps = {gated_sh_r[14:0], l_out};
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sys_sh_r <= 16'h0000;
            gated_sh_r <= 16'h0000;
        end
        else
        begin
            if (pix_tick)
                sys_sh_r <= sys_taps;
            if (s_tick)
                gated_sh_r <= gated_taps;
        end
    end

    // Output selection; divider-sourced system clock sits static low when divide is one
    wire sys_from_div = (sys_div == 4'h0) ? 1'b0 : sys_taps[system_phase_delay];
    wire sys_clk_nxt = sys_src_divider ? sys_from_div : xtal_clk_in;
    wire gated_nxt = ttl_gated_out_disable || gated_taps[gated_phase_delay];
    wire load_nxt = load_out_disable || (l_run && l_out);
    wire fb_nxt = divider_mode_select ? n_out : h_out;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            sys_clk_r <= 1'b0;
            gated_clk_r <= 1'b0;
            load_r <= 1'b0;
            fb_r <= 1'b0;
        end
        else
        begin
            sys_clk_r <= sys_clk_nxt;
            gated_clk_r <= gated_nxt;
            load_r <= load_nxt;
            fb_r <= fb_nxt;
        end
    end

    // Feedback pin drive; the comparator sees the pin when floated
    assign feedback_pin_o = fb_r;
    assign feedback_pin_oe = !feedback_output_tristate;
    assign comparator_fbk = feedback_output_tristate ? feedback_pin_i : fb_r;

    // Clock output bundle; disabled outputs sit high
    assign clk_out.pixel_clk_out = ttl_pixel_out_disable
        || (pixel_clk_in ^ pixel_polarity_invert);
    assign clk_out.sys_clk_out = sys_clk_r;
    assign clk_out.load_clk_out = load_r;
    assign clk_out.gated_clk_out = gated_clk_r;
    assign clk_out.ref_clk_out = w_aux[PCG_BIT_REF_DIS] || ref_div_in;

    // Static controls to the analog section
    assign analog_ctl.ref_divide = {ctl_r[PCG_ADR_REF_NIB2], ctl_r[PCG_ADR_REF_NIB1],
                                    ctl_r[PCG_ADR_REF_NIB0]};
    assign analog_ctl.pix_divide_exp = w_pix[2:0];
    assign analog_ctl.pump1_disable = w_out[PCG_BIT_PUMP1_DIS];
    assign analog_ctl.pump2_disable = w_out[PCG_BIT_PUMP2_DIS];
    assign analog_ctl.ring_current_ratio_hi = w_osc[PCG_BIT_RING_HI];
    assign analog_ctl.ring_current_ratio_lo = w_osc[PCG_BIT_RING_LO];
    assign analog_ctl.oscillator_test_mode = w_fb_cfg[PCG_BIT_TEST_MODE];
    assign analog_ctl.oscillator_disable_bit = w_osc[PCG_BIT_OSC_DIS];
    assign analog_ctl.oscillator_reset_bit = w_osc[PCG_BIT_OSC_RST];
    assign ref_out_disable = w_aux[PCG_BIT_REF_DIS];
endmodule : pcg_regs

// *** shared/pcg_pkg.sv ***
// Constants and types shared by the programmable clock divider register block
package pcg_pkg;
    // Control word addresses
    localparam logic [3:0] PCG_ADR_FB_NIB0 = 4'h0;
    localparam logic [3:0] PCG_ADR_FB_NIB1 = 4'h1;
    localparam logic [3:0] PCG_ADR_FB_NIB2 = 4'h2;
    localparam logic [3:0] PCG_ADR_FB_NIB3 = 4'h3;
    localparam logic [3:0] PCG_ADR_REF_NIB0 = 4'h4;
    localparam logic [3:0] PCG_ADR_REF_NIB1 = 4'h5;
    localparam logic [3:0] PCG_ADR_REF_NIB2 = 4'h6;
    localparam logic [3:0] PCG_ADR_SYS_DIV = 4'h7;
    localparam logic [3:0] PCG_ADR_LOAD_DIV = 4'h8;
    localparam logic [3:0] PCG_ADR_PIX_POL = 4'h9;
    localparam logic [3:0] PCG_ADR_OUT_PUMP = 4'ha;
    localparam logic [3:0] PCG_ADR_FB_CFG = 4'hb;
    localparam logic [3:0] PCG_ADR_OSC_CTL = 4'hc;
    localparam logic [3:0] PCG_ADR_AUX_DIS = 4'hd;
    localparam logic [3:0] PCG_ADR_SYS_PHASE = 4'he;
    localparam logic [3:0] PCG_ADR_GATED_PHASE = 4'hf;
    // Field positions inside the configuration words
    localparam int PCG_BIT_PIX_INV = 3;
    localparam int PCG_BIT_PUMP2_DIS = 0;
    localparam int PCG_BIT_PUMP1_DIS = 1;
    localparam int PCG_BIT_TTL_GATED_DIS = 2;
    localparam int PCG_BIT_TTL_PIX_DIS = 3;
    localparam int PCG_BIT_TEST_MODE = 0;
    localparam int PCG_BIT_SYS_SRC = 1;
    localparam int PCG_BIT_MODE_SEL = 2;
    localparam int PCG_BIT_FB_TRI = 3;
    localparam int PCG_BIT_RING_LO = 0;
    localparam int PCG_BIT_RING_HI = 1;
    localparam int PCG_BIT_OSC_RST = 2;
    localparam int PCG_BIT_OSC_DIS = 3;
    localparam int PCG_BIT_LOAD_DIS = 0;
    localparam int PCG_BIT_REF_DIS = 3;
    // Value after reset of every control word
    localparam logic [3:0] PCG_CTL_RESET = 4'h0;
    // Dual-modulus high time in oscillator periods; horizontal high time in load periods
    localparam logic [15:0] PCG_N_HIGH_LEN = 16'h0020;
    localparam logic [11:0] PCG_H_HIGH_LEN = 12'h001;
    // Oscillator restart sequence, least time
    localparam int PCG_CLK_PERIOD_NS = 50;
    localparam int PCG_RESTART_NS = 1000;
    localparam int PCG_RESTART_CYC =
        (PCG_RESTART_NS + PCG_CLK_PERIOD_NS - 1) / PCG_CLK_PERIOD_NS;
    localparam logic [7:0] PCG_RESTART_CNT = 8'(PCG_RESTART_CYC);

    // Static controls handed to the analog section
    typedef struct packed {
        logic [11:0] ref_divide;
        logic [2:0] pix_divide_exp;
        logic pump1_disable;
        logic pump2_disable;
        logic ring_current_ratio_hi;
        logic ring_current_ratio_lo;
        logic oscillator_test_mode;
        logic oscillator_disable_bit;
        logic oscillator_reset_bit;
    } pcg_analog_t;

    // Clock outputs of the digital section
    typedef struct packed {
        logic pixel_clk_out;
        logic sys_clk_out;
        logic load_clk_out;
        logic gated_clk_out;
        logic ref_clk_out;
    } pcg_clocks_t;
endpackage : pcg_pkg

// *** hdl/pcg_div.sv ***
// Programmable modulus divider with glitch-free modulus reload
`timescale 1ns/1ns
module pcg_div
    import pcg_pkg::*;
#(
    parameter int W = 16
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] modulus,
    input wire logic [W-1:0] high_len,
    output logic out_lvl,
    output logic term
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] mod_r;
    logic [W-1:0] hi_r;
    logic [W-1:0] cnt_nxt;
    logic [W-1:0] mod_nxt;
    logic [W-1:0] hi_nxt;

    // Terminal count; a zero modulus behaves as divide by one
    wire last = (mod_r <= W'(1)) || (cnt_r == mod_r - W'(1));
    assign term = run && tick && last;

    // New modulus taken at terminal count or while stopped, so no pulse is cut short
    always_comb
    begin
        cnt_nxt = cnt_r;
        mod_nxt = mod_r;
        hi_nxt = hi_r;
        if (!run)
        begin
            cnt_nxt = '0;
            mod_nxt = modulus;
            hi_nxt = high_len;
        end
        else if (tick)
        begin
            if (last)
            begin
                cnt_nxt = '0;
                mod_nxt = modulus;
                hi_nxt = high_len;
            end
            else
            begin
                cnt_nxt = cnt_r + W'(1);
            end
        end
    end

    // Output is high for the first high_len counts of each cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cnt_r <= '0;
            mod_r <= '0;
            hi_r <= '0;
            out_lvl <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            mod_r <= mod_nxt;
            hi_r <= hi_nxt;
            out_lvl <= run && (cnt_nxt < hi_nxt);
        end
    end
endmodule : pcg_div

// *** tb/pcg_host_model.sv ***
// Host model that writes control words over the four-bit strobe bus
`timescale 1ns/1ns
module pcg_host_model
(
    input wire logic clk_sys,
    output logic [3:0] ctl_addr,
    output logic [3:0] ctl_data,
    output logic ctl_enable
);
    // Idle bus at time zero, strobe low
    initial
    begin
        ctl_addr = 4'h0;
        ctl_data = 4'h0;
        ctl_enable = 1'b0;
    end

    // Lines settle a cycle ahead of the strobe and hold through its pulse
    task automatic write_word(input logic [3:0] addr, input logic [3:0] data);
        @(posedge clk_sys);
        #2;
        ctl_addr = addr;
        ctl_data = data;
        @(posedge clk_sys);
        #2;
        ctl_enable = 1'b1;
        @(posedge clk_sys);
        #2;
        ctl_enable = 1'b0;
        @(posedge clk_sys);
        #2;
        // Hold over: invert so a late sample cannot match by luck
        ctl_addr = ~addr;
        ctl_data = ~data;
    endtask : write_word
endmodule : pcg_host_model

// *** tb/pcg_regs_props.sv ***
// Concurrent checks on the control word block ports
`timescale 1ns/1ns
module pcg_regs_props
    import pcg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] ctl_addr,
    input wire logic [3:0] ctl_data,
    input wire logic ctl_enable,
    input wire logic xtal_clk_in,
    input wire logic feedback_pin_i,
    input wire logic feedback_pin_o,
    input wire logic feedback_pin_oe,
    input wire logic comparator_fbk,
    input wire pcg_clocks_t clk_out,
    input wire pcg_analog_t analog_ctl
);
    logic en_r;
    logic [3:0] w8_r;
    logic [3:0] w11_r;
    logic [3:0] w13_r;
    wire logic wr_take = ctl_enable && !en_r;

    // Shadow of the few words the checks depend on
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            en_r <= 1'b0;
            w8_r <= 4'h0;
            w11_r <= 4'h0;
            w13_r <= 4'h0;
        end
        else
        begin
            en_r <= ctl_enable;
            if (wr_take && ctl_addr == 4'h8) w8_r <= ctl_data;
            if (wr_take && ctl_addr == 4'hb) w11_r <= ctl_data;
            if (wr_take && ctl_addr == 4'hd) w13_r <= ctl_data;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_reset_clear: assert property ($rose(rst_b) |->
        !analog_ctl.oscillator_test_mode && !analog_ctl.oscillator_disable_bit)
        else $error("oscillator bits not clear after reset");
    chk_osc_set: assert property (wr_take && ctl_addr == 4'hc && ctl_data[2] |=>
        analog_ctl.oscillator_reset_bit) else $error("oscillator reset bit not set");
    chk_osc_clear: assert property ($rose(analog_ctl.oscillator_reset_bit) |->
        ##[1:40] !analog_ctl.oscillator_reset_bit) else $error("oscillator reset stuck");
    chk_ref_store: assert property (wr_take && ctl_addr == 4'h4 |=>
        analog_ctl.ref_divide[3:0] == $past(ctl_data)) else $error("word 4 not stored");
    chk_oe_bit: assert property (feedback_pin_oe == !w11_r[3])
        else $error("feedback drive disagrees with word 11");
    chk_fbk_source: assert property (comparator_fbk ==
        (feedback_pin_oe ? feedback_pin_o : feedback_pin_i)) else $error("comparator source");
    chk_load_stop: assert property ((w8_r == 4'h0 && !w13_r[0])[*3] |->
        !clk_out.load_clk_out) else $error("load clock runs at divide by one");
    chk_sys_xtal: assert property ((!w11_r[1])[*2] |->
        clk_out.sys_clk_out == $past(xtal_clk_in)) else $error("system clock not crystal");
endmodule : pcg_regs_props

bind pcg_regs pcg_regs_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .ctl_addr(ctl_addr),
    .ctl_data(ctl_data), .ctl_enable(ctl_enable), .xtal_clk_in(xtal_clk_in),
    .feedback_pin_i(feedback_pin_i), .feedback_pin_o(feedback_pin_o),
    .feedback_pin_oe(feedback_pin_oe), .comparator_fbk(comparator_fbk),
    .clk_out(clk_out), .analog_ctl(analog_ctl));

// *** tb/tb_top.sv ***
// Self-checking bench for the clock generator control word block
`timescale 1ns/1ns
module tb_top;
    import pcg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic vco_clk_in = 1'b0;
    logic pixel_clk_in = 1'b0;
    logic xtal_clk_in = 1'b0;
    logic ref_div_in = 1'b0;
    logic fb_ext = 1'b1;
    wire logic [3:0] ctl_addr;
    wire logic [3:0] ctl_data;
    wire logic ctl_enable;
    logic fb_o;
    logic fb_oe;
    logic fb_cmp;
    logic ref_dis;
    pcg_clocks_t clk_out;
    pcg_analog_t ana;
    int bad_count = 0;
    int check_count = 0;
    int hi;
    int lo;
    logic [7:0] map_tab [6] = '{8'h4a, 8'h55, 8'h63, 8'h95, 8'ha3, 8'hd8};
    logic [15:0] n_tab [2] = '{16'h0028, 16'h0041};
    // Pin level seen by the block; released pin reads the outside level
    wire logic fb_pin = fb_oe ? fb_o : fb_ext;
    wire logic [3:0] probe = {fb_o, clk_out.load_clk_out, clk_out.sys_clk_out,
        clk_out.gated_clk_out};

    pcg_host_model host (.clk_sys(clk_sys), .ctl_addr(ctl_addr), .ctl_data(ctl_data),
        .ctl_enable(ctl_enable));
    pcg_regs uut (.clk_sys(clk_sys), .rst_b(rst_b), .ctl_addr(ctl_addr), .ctl_data(ctl_data),
        .ctl_enable(ctl_enable), .vco_clk_in(vco_clk_in), .pixel_clk_in(pixel_clk_in),
        .xtal_clk_in(xtal_clk_in), .ref_div_in(ref_div_in), .feedback_pin_i(fb_pin),
        .feedback_pin_o(fb_o), .feedback_pin_oe(fb_oe), .comparator_fbk(fb_cmp),
        .clk_out(clk_out), .analog_ctl(ana), .ref_out_disable(ref_dis));

    always #25 clk_sys = ~clk_sys;
    // Slow clocks toggle once a cycle, so one tick every two cycles
    always @(posedge clk_sys)
    begin
        #2;
        vco_clk_in = ~vco_clk_in;
        pixel_clk_in = ~pixel_clk_in;
        xtal_clk_in = ~xtal_clk_in;
        ref_div_in = ~ref_div_in;
    end

    task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_vec

    task automatic check_num(input string what, input int exp, input int got);
        check_count++;
        if (got != exp)
        begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    // Cycles until the probed output rises; 3000 means it never did
    task automatic wait_rise(input int idx, output int n);
        logic prev;
        n = 0;
        prev = 1'b1;
        while (n < 3000 && !(prev === 1'b0 && probe[idx] === 1'b1))
        begin
            prev = probe[idx];
            step(1);
            n++;
        end
    endtask : wait_rise

    task automatic measure(input int idx, output int h, output int l);
        int d;
        wait_rise(idx, d);
        h = 0;
        l = 0;
        while (probe[idx] === 1'b1 && h < 3000)
        begin
            step(1);
            h++;
        end
        while (probe[idx] === 1'b0 && l < 3000)
        begin
            step(1);
            l++;
        end
    endtask : measure

    // Phase shift seen between load rise and the output, delay 0 against 1
    task automatic shift_test(input logic [3:0] addr, input int idx, input int per,
        output int sh);
        int d;
        int g0;
        int g1;
        host.write_word(addr, 4'h0);
        step(20);
        wait_rise(2, d);
        wait_rise(idx, g0);
        host.write_word(addr, 4'h1);
        step(20);
        wait_rise(2, d);
        wait_rise(idx, g1);
        sh = (g1 - g0 + 2 * per) % per;
    endtask : shift_test

    // Inverted low field kept at five bits so the cast cannot widen the inversion
    function automatic int nmod(input logic [15:0] v);
        logic [4:0] a_inv;
        a_inv = ~v[4:0];
        return 32 * (int'(v[15:5]) - int'(a_inv)) + 31 * (1 + int'(a_inv));
    endfunction : nmod

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    // Hang guard, well past the expected run length
    initial
    begin
        #(80000 * 50);
        bad_count++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        step(2);
        check_vec("test mode", 16'h0000, ana.oscillator_test_mode);
        check_vec("osc disable", 16'h0000, ana.oscillator_disable_bit);
        check_vec("pin drive", 16'h0001, fb_oe);
        foreach (map_tab[i])
            host.write_word(map_tab[i][7:4], map_tab[i][3:0]);
        check_vec("ref divide", 16'h035a, ana.ref_divide);
        check_vec("pixel out", pixel_clk_in, clk_out.pixel_clk_out);
        check_vec("ref out high", 16'h0001, clk_out.ref_clk_out);
        check_vec("pixel exponent", 16'h0005, ana.pix_divide_exp);
        check_vec("pumps", 16'h0003, {ana.pump1_disable, ana.pump2_disable});
        check_vec("ref disable", 16'h0001, ref_dis);
        host.write_word(4'hc, 4'h6);
        check_vec("osc reset set", 16'h0003, {ana.ring_current_ratio_hi,
            ana.oscillator_reset_bit});
        step(30);
        check_vec("osc reset clear", 16'h0002, {ana.ring_current_ratio_hi,
            ana.oscillator_reset_bit});
        host.write_word(4'hb, 4'h8);
        fb_ext = 1'b0;
        step(1);
        check_vec("pin float low", 16'h0000, {fb_oe, fb_cmp});
        #1;
        fb_ext = 1'b1;
        step(1);
        check_vec("pin float high", 16'h0001, {fb_oe, fb_cmp});
        // Dual-modulus values; second period read so a reload cannot blur it
        foreach (n_tab[i])
        begin
            for (int k = 0; k < 4; k++)
                host.write_word(4'(k), n_tab[i][4*k +: 4]);
            host.write_word(4'hb, 4'h4);
            measure(3, hi, lo);
            measure(3, hi, lo);
            check_num("n high", 64, hi);
            check_num("n low", 2 * (nmod(n_tab[i]) - 32), lo);
        end
        host.write_word(4'hb, 4'h0);
        host.write_word(4'h7, 4'h0);
        host.write_word(4'h8, 4'h1);
        host.write_word(4'h1, 4'h5);
        host.write_word(4'h0, 4'hf);
        measure(2, hi, lo);
        check_num("load high even", 2, hi);
        check_num("load low even", 2, lo);
        measure(3, hi, lo);
        measure(3, hi, lo);
        check_num("h high", 4, hi);
        check_num("h low", 8, lo);
        host.write_word(4'h8, 4'h2);
        measure(2, hi, lo);
        measure(2, hi, lo);
        check_num("load high odd", 2, hi);
        check_num("load low odd", 4, lo);
        host.write_word(4'h8, 4'h0);
        step(4);
        wait_rise(2, hi);
        check_num("load idle", 3000, hi);
        wait_rise(3, hi);
        check_num("h idle", 3000, hi);
        host.write_word(4'h8, 4'h1);
        host.write_word(4'h7, 4'h1);
        host.write_word(4'hb, 4'h2);
        shift_test(4'he, 1, 4, hi);
        check_num("system shift", 2, hi);
        shift_test(4'hf, 0, 8, hi);
        check_num("gated shift", 4, hi);
        stop_test();
    end
endmodule : tb_top
